// *** dv/bil_flash_model.sv ***
/*
  Behavioural quad-SPI flash holding one boot image, mode 0 only.
  Assumes the bench resolves the data wires from the loader's enables alone.
*/
`timescale 1ns/1ps

module bil_flash_model #(
  parameter int NB = 32
) (
  input  wire logic            ss_n_i,
  input  wire logic            sclk_i,
  input  wire logic [3:0]      d_i,
  input  wire logic [3:0]      d_oe_i,
  input  wire logic [8*NB-1:0] image_i,
  output logic      [3:0]      d_o,
  output logic                 err_o
);
  logic [31:0] cmd_r;
  logic [3:0]  last_r;
  int          bits;
  int          nib;
  initial begin
    err_o  = 1'b0;
    d_o    = 4'h0;
    last_r = 4'h0;
  end
  always @(negedge ss_n_i) begin
    bits = 0;
    nib  = 0;
    if (sclk_i) err_o = 1'b1;
  end
  // released lines: inverse of the last nibble, no pull-up on the board
  always @(posedge ss_n_i) begin
    if (sclk_i) err_o = 1'b1;
    // the first reset edge of the select line is no frame
    if (bits > 0 && nib != (image_i[31:0] + 2) * 8) err_o = 1'b1;
    d_o = ~last_r;
  end
  always @(posedge sclk_i) begin
    if (!ss_n_i && bits < 32) begin
      cmd_r = {cmd_r[30:0], d_i[0]};
      bits++;
      if (bits == 32 && cmd_r !== 32'h03000000) err_o = 1'b1;
    end
  end
  // launch on the falling edge so the rising edge sees settled data
  always @(negedge sclk_i) begin
    if (!ss_n_i && bits == 32) begin
      if (d_oe_i !== 4'h0) err_o = 1'b1;
      last_r = (nib < 2 * NB) ? image_i[4*nib +: 4] : ~last_r;
      d_o = last_r;
      nib++;
    end
  end
endmodule

// *** dv/testbench.sv ***
/*
  Self-checking bench of the boot loader: flash, OTP and strap boots.
  Assumes the loader's 1500-cycle reset phase at 100 MHz.
*/
`timescale 1ns/1ps
`include "bil_consts.svh"

module testbench
  import bil_pkg::*;
();
  localparam int NB = 32;
  logic                   mclk_i;
  logic                   rst_n_i;
  logic [2:0]             boot_strap_i;
  logic [31:0]            security_reg_i;
  logic [7:0]             otp_data_i;
  logic                   otp_ack_i;
  logic [`BIL_RAM_AW-1:0] ram_raddr_i;
  bil_qspi_out_t          qspi;
  logic                   pin_en;
  logic                   pd;
  logic                   otp_rd;
  logic [`BIL_OTP_AW-1:0] otp_addr;
  bil_boot_cfg_t          cfg;
  logic                   exec;
  logic [`BIL_RAM_AW-1:0] exec_addr;
  logic                   berr;
  logic [31:0]            rdata;
  logic [3:0]             fl_d;
  logic [3:0]             qd;
  logic                   fl_err;
  logic [8*NB-1:0]        img;
  logic                   rd_d1;
  logic                   got;
  logic [15:0]            first_a;
  int                     err_total;
  int                     checks_done;
  int                     n;
  int                     k;
  bil_boot_cfg_t          tbl [1:5];

  assign qd = (qspi.d_oe & qspi.d_o) | (~qspi.d_oe & fl_d);

  bil_loader i_bil_loader (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .boot_strap_i(boot_strap_i),
    .security_reg_i(security_reg_i), .quad_data_lines_i(qd), .otp_data_i(otp_data_i),
    .otp_ack_i(otp_ack_i), .ram_raddr_i(ram_raddr_i), .qspi_o(qspi), .qspi_pin_en_o(pin_en),
    .gpio_pulldown_o(pd), .otp_rd_o(otp_rd), .otp_addr_o(otp_addr), .boot_cfg_o(cfg),
    .exec_start_o(exec), .exec_addr_o(exec_addr), .boot_error_o(berr), .ram_rdata_o(rdata));

  bil_flash_model #(.NB(NB)) i_bil_flash_model (.ss_n_i(qspi.ss_n), .sclk_i(qspi.sclk), .d_i(qd),
    .d_oe_i(qspi.d_oe), .image_i(img), .d_o(fl_d), .err_o(fl_err));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // otp answers two cycles after each request, garbage otherwise
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_d1      <= 1'b0;
      otp_ack_i  <= 1'b0;
      otp_data_i <= 8'h00;
      got        <= 1'b0;
    end else begin
      rd_d1      <= otp_rd;
      otp_ack_i  <= rd_d1;
      otp_data_i <= rd_d1 ? img[8*otp_addr[4:0] +: 8] : ~img[8*otp_addr[4:0] +: 8];
      if (otp_rd && !got) begin
        got     <= 1'b1;
        first_a <= otp_addr;
      end
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] crc_of(input logic [8*NB-1:0] b, input int nb);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < nb; i++) begin
      c ^= {24'h0, b[8*i +: 8]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  // kind 0 good check word, 1 bypass word, 2 corrupted check word
  task automatic mk(input int w, input int kind);
    img = '0;
    img[31:0] = w;
    for (int i = 0; i < w; i++) img[32*(i+1) +: 32] = 32'ha5c30f01 + i * 32'h11223344;
    img[32*(w+1) +: 32] = kind == 1 ? 32'h0d15ab1e : crc_of(img, 4 * (w + 1)) ^ (kind == 2);
  endtask

  task automatic boot(input logic [2:0] s, input logic sec);
    @(posedge mclk_i);
    rst_n_i        <= 1'b0;
    boot_strap_i   <= s;
    security_reg_i <= {26'h0, sec, 5'h0};
    repeat (5) @(posedge mclk_i);
    chk({pd, qspi.ss_n, qspi.sclk, exec, berr}, 5'b11000);
    rst_n_i <= 1'b1;
    for (n = 0; n < 1600 && qspi.ss_n; n++) @(posedge mclk_i);
  endtask

  task automatic done(input int w);
    for (k = 0; k < 4000 && !(exec || berr); k++) @(posedge mclk_i);
    if (k == 4000) begin
      err_total++;
      print_verdict();
    end
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < w; i++) begin
      ram_raddr_i <= i[`BIL_RAM_AW-1:0];
      repeat (2) @(posedge mclk_i);
      chk(rdata, img[32*(i+1) +: 32]);
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    boot_strap_i = 3'h0;
    security_reg_i = 32'h0;
    ram_raddr_i = '0;
    err_total = 0;
    checks_done = 0;
    tbl[1] = '{BIL_MODE_SPI_M, BIL_MODE_CHAN0, 1'b0, 1'b0};
    tbl[2] = '{BIL_MODE_SPI_S, BIL_MODE_CHAN0, 1'b0, 1'b0};
    tbl[3] = '{BIL_MODE_SPI_S, BIL_MODE_SPI_S, 1'b0, 1'b0};
    tbl[4] = '{BIL_MODE_CHAN0, BIL_MODE_CHAN0, 1'b1, 1'b1};
    tbl[5] = '{BIL_MODE_NONE, BIL_MODE_NONE, 1'b0, 1'b0};
    mk(3, 0);
    boot(3'h0, 1'b0);
    chk(32'(n >= 1495 && n <= 1510), 1);
    chk(cfg, {BIL_MODE_QSPI_M, BIL_MODE_CHAN0, 2'b00});
    for (k = 0; k < 20 && !qspi.sclk; k++) @(posedge mclk_i);
    for (k = 0; k < 20 && qspi.sclk; k++) @(posedge mclk_i);
    for (; k < 20 && !qspi.sclk; k++) @(posedge mclk_i);
    chk(k, 8);
    chk({pin_en, pd}, 2'b10);
    done(3);
    chk({exec, berr, 20'h0, exec_addr}, 32'h80000000);
    chk(fl_err, 0);
    mk(0, 1);
    boot(3'h0, 1'b0);
    done(0);
    chk({exec, berr}, 2'b10);
    mk(2, 2);
    boot(3'h0, 1'b0);
    done(0);
    chk({exec, berr}, 2'b01);
    mk(2, 0);
    boot(3'h0, 1'b1);
    chk(n, 1600);
    chk(cfg.tile0, BIL_MODE_OTP);
    done(2);
    chk({exec, berr, got, first_a}, {3'b101, 16'h0});
    for (int s = 1; s <= 5; s++) begin
      boot(s[2:0], 1'b0);
      chk({qspi.ss_n, pin_en, pd, cfg}, {3'b101, tbl[s]});
    end
    chk(fl_err, 0);
    print_verdict();
  end
endmodule

// *** include/bil_consts.svh ***
/*
  Constants of the boot image loader: image format words, CRC setup,
  flash command, reset-phase timing and memory sizes.
  Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef BIL_CONSTS_SVH
`define BIL_CONSTS_SVH

`define BIL_SECURE_BIT      5
`define BIL_BYPASS_WORD     32'h0d15ab1e
`define BIL_CRC_POLY        32'hedb88320
`define BIL_CRC_INIT        32'hffffffff
`define BIL_READ_CMD        8'h03
`define BIL_FLASH_ADDR      24'h000000
`define BIL_CMD_BITS        6'h20
`define BIL_OTP_AW          16
`define BIL_OTP_START       16'h0000
`define BIL_RAM_AW          10
`define BIL_RAM_START       10'h000
`define BIL_CLK_PERIOD_NS   10
`define BIL_RST_PHASE_NS    15000
`define BIL_RST_PHASE_CYC   ((`BIL_RST_PHASE_NS + `BIL_CLK_PERIOD_NS - 1) / `BIL_CLK_PERIOD_NS)
`define BIL_SCLK_DIV        8
`define BIL_SCLK_RISE       3'h3
`define BIL_SCLK_LAST_HI    3'h6
`define BIL_STRAP_QSPI_M    3'h0
`define BIL_STRAP_SPI_M     3'h1
`define BIL_STRAP_SPI_S     3'h2
`define BIL_STRAP_SPI_S2    3'h3
`define BIL_STRAP_CHAN      3'h4

`endif

// *** include/bil_pkg.sv ***
/*
  Types of the boot image loader: states, boot modes, image phases and
  the grouped pin and configuration carriers.
  Assumes bil_consts.svh for all numeric constants.
*/
package bil_pkg;

  typedef enum logic [8:0] {
    BIL_ST_RST  = 9'h001,
    BIL_ST_SEL  = 9'h002,
    BIL_ST_CMD  = 9'h004,
    BIL_ST_DATA = 9'h008,
    BIL_ST_OTP  = 9'h010,
    BIL_ST_CHK  = 9'h020,
    BIL_ST_RUN  = 9'h040,
    BIL_ST_ERR  = 9'h080,
    BIL_ST_EXT  = 9'h100
  } bil_state_t;

  typedef enum logic [2:0] {
    BIL_MODE_NONE   = 3'h0,
    BIL_MODE_QSPI_M = 3'h1,
    BIL_MODE_SPI_M  = 3'h2,
    BIL_MODE_SPI_S  = 3'h3,
    BIL_MODE_CHAN0  = 3'h4,
    BIL_MODE_OTP    = 3'h5
  } bil_mode_t;

  typedef enum logic [1:0] {
    BIL_PH_SIZE = 2'h0,
    BIL_PH_PROG = 2'h1,
    BIL_PH_CRC  = 2'h2
  } bil_phase_t;

  typedef struct packed {
    logic       ss_n;
    logic       sclk;
    logic [3:0] d_o;
    logic [3:0] d_oe;
  } bil_qspi_out_t;

  typedef struct packed {
    bil_mode_t tile0;
    bil_mode_t tile1;
    logic      link0_en;
    logic      link0_2w;
  } bil_boot_cfg_t;

endpackage

// *** rtl/bil_crc32.sv ***
/*
  Byte-serial reflected CRC-32 register.
  Assumes bytes arrive one per enable in stream order; init has priority.
*/
`timescale 1ns/1ps
`include "bil_consts.svh"

module bil_crc32 (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        init_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  byte_i,
  output logic      [31:0] crc_o
);

  function automatic logic [31:0] bil_crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_o <= `BIL_CRC_INIT;
    end else if (init_i) begin
      crc_o <= `BIL_CRC_INIT;
    end else if (en_i) begin
      crc_o <= bil_crc_byte(crc_o, byte_i);
    end
  end

endmodule

// *** rtl/bil_loader.sv ***
/*
  Boot sequencer of one tile: reset phase, boot source selection from
  straps or secure bit, quad-SPI flash read or OTP byte fetch, image
  parsing into RAM, CRC check and start of execution.
  Assumes straps and quad data lines are asynchronous pins, the security
  register and OTP port run on mclk_i, and the pad ring merges the data
  line enables into the wires.
*/
`timescale 1ns/1ps
`include "bil_consts.svh"

module bil_loader
  import bil_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [2:0]             boot_strap_i,
  input  wire logic [31:0]            security_reg_i,
  input  wire logic [3:0]             quad_data_lines_i,
  input  wire logic [7:0]             otp_data_i,
  input  wire logic                   otp_ack_i,
  input  wire logic [`BIL_RAM_AW-1:0] ram_raddr_i,
  output bil_qspi_out_t               qspi_o,
  output logic                        qspi_pin_en_o,
  output logic                        gpio_pulldown_o,
  output logic                        otp_rd_o,
  output logic [`BIL_OTP_AW-1:0]      otp_addr_o,
  output bil_boot_cfg_t               boot_cfg_o,
  output logic                        exec_start_o,
  output logic [`BIL_RAM_AW-1:0]      exec_addr_o,
  output logic                        boot_error_o,
  output logic [31:0]                 ram_rdata_o
);

  localparam int unsigned RST_CYC = `BIL_RST_PHASE_CYC;
  localparam logic [10:0] RST_LAST = 11'(RST_CYC - 1);
  localparam logic [31:0] RAM_WORDS = 32'(1 << `BIL_RAM_AW);

  function automatic bil_boot_cfg_t bil_decode(input logic [2:0] s);
    bil_boot_cfg_t c;
    c = '{tile0: BIL_MODE_NONE, tile1: BIL_MODE_NONE, link0_en: 1'b0, link0_2w: 1'b0};
    case (s)
      `BIL_STRAP_QSPI_M: begin
        c.tile0 = BIL_MODE_QSPI_M;
        c.tile1 = BIL_MODE_CHAN0;
      end
      `BIL_STRAP_SPI_M: begin
        c.tile0 = BIL_MODE_SPI_M;
        c.tile1 = BIL_MODE_CHAN0;
      end
      `BIL_STRAP_SPI_S: begin
        c.tile0 = BIL_MODE_SPI_S;
        c.tile1 = BIL_MODE_CHAN0;
      end
      `BIL_STRAP_SPI_S2: begin
        c.tile0 = BIL_MODE_SPI_S;
        c.tile1 = BIL_MODE_SPI_S;
      end
      `BIL_STRAP_CHAN: begin
        c.tile0    = BIL_MODE_CHAN0;
        c.tile1    = BIL_MODE_CHAN0;
        c.link0_en = 1'b1;
        c.link0_2w = 1'b1;
      end
      default: begin
        c.tile0 = BIL_MODE_NONE;
      end
    endcase
    return c;
  endfunction

  bil_state_t                st_r;
  bil_state_t                st_nxt;
  bil_phase_t                ph_r;
  bil_qspi_out_t             qo_r;
  bil_qspi_out_t             qo_nxt;
  bil_boot_cfg_t             cfg_r;
  logic [10:0]               rst_cnt_r;
  logic [2:0]                strap_s1_r, strap_s2_r, strap_s3_r, strap_f_r;
  logic [3:0]                dq_s1_r, dq_s2_r, dq_s3_r, dq_f_r;
  logic [2:0]                div_r;
  logic [5:0]                bit_cnt_r;
  logic [31:0]               sh_r;
  logic [31:0]               sh_nxt;
  logic [3:0]                nib_lo_r;
  logic                      nib_hi_r;
  logic [1:0]                pos_r;
  logic [31:0]               word_sh_r;
  logic [31:0]               size_r;
  logic [31:0]               wr_cnt_r;
  logic [31:0]               chk_r;
  logic                      size_bad_r;
  logic [`BIL_RAM_AW-1:0]    wr_addr_r;
  logic                      otp_pend_r;
  logic                      otp_rd_r;
  logic [`BIL_OTP_AW-1:0]    otp_addr_r;
  logic                      pin_en_r;
  logic                      pulldown_r;
  logic                      run_r;
  logic                      err_r;
  logic [31:0]               crc;

  wire bil_boot_cfg_t cfg_dec   = bil_decode(strap_f_r);
  wire logic   secure      = security_reg_i[`BIL_SECURE_BIT];
  wire logic   rst_done    = (st_r == BIL_ST_RST) && (rst_cnt_r == RST_LAST);
  wire logic   clk_run     = (st_r == BIL_ST_CMD) || (st_r == BIL_ST_DATA);
  wire logic   per_end     = clk_run && (div_r == 3'(`BIL_SCLK_DIV - 1));
  wire logic   cmd_last    = per_end && (st_r == BIL_ST_CMD) && (bit_cnt_r == `BIL_CMD_BITS - 6'h01);
  wire logic   nib_take    = per_end && (st_r == BIL_ST_DATA);
  wire logic   q_byte_vld  = nib_take && nib_hi_r;
  wire logic   otp_take    = (st_r == BIL_ST_OTP) && otp_pend_r && otp_ack_i;
  wire logic   byte_vld    = q_byte_vld || otp_take;
  wire logic [7:0]  byte_val = otp_take ? otp_data_i : {dq_f_r, nib_lo_r};
  wire logic   word_done   = byte_vld && (pos_r == 2'h3);
  wire logic [31:0] word_val = {byte_val, word_sh_r[31:8]};
  wire logic   img_done    = word_done && (ph_r == BIL_PH_CRC);
  wire logic   ram_we      = word_done && (ph_r == BIL_PH_PROG);
  wire logic   prog_last   = ram_we && (wr_cnt_r == size_r - 32'h1);
  wire logic   crc_en      = byte_vld && (ph_r != BIL_PH_CRC);
  wire logic   bypass      = (chk_r == `BIL_BYPASS_WORD);
  wire logic   crc_match   = ((~crc) == chk_r);
  wire logic   chk_pass    = (bypass || crc_match) && !size_bad_r;
  wire logic   in_flash    = (st_nxt == BIL_ST_SEL) || (st_nxt == BIL_ST_CMD) || (st_nxt == BIL_ST_DATA);
  wire logic   drive_cmd   = (st_nxt == BIL_ST_SEL) || (st_nxt == BIL_ST_CMD);
  wire logic   sclk_hi     = clk_run && (div_r >= `BIL_SCLK_RISE) && (div_r <= `BIL_SCLK_LAST_HI);

  always_comb begin
    case (st_r)
      BIL_ST_RST: begin
        if (!rst_done) begin
          st_nxt = BIL_ST_RST;
        end else if (secure) begin
          st_nxt = BIL_ST_OTP;
        end else if (cfg_dec.tile0 == BIL_MODE_QSPI_M) begin
          st_nxt = BIL_ST_SEL;
        end else begin
          st_nxt = BIL_ST_EXT;
        end
      end
      BIL_ST_SEL:  st_nxt = BIL_ST_CMD;
      BIL_ST_CMD:  st_nxt = cmd_last ? BIL_ST_DATA : BIL_ST_CMD;
      BIL_ST_DATA: st_nxt = img_done ? BIL_ST_CHK : BIL_ST_DATA;
      BIL_ST_OTP:  st_nxt = img_done ? BIL_ST_CHK : BIL_ST_OTP;
      BIL_ST_CHK:  st_nxt = chk_pass ? BIL_ST_RUN : BIL_ST_ERR;
      BIL_ST_RUN:  st_nxt = BIL_ST_RUN;
      BIL_ST_ERR:  st_nxt = BIL_ST_ERR;
      BIL_ST_EXT:  st_nxt = BIL_ST_EXT;
      default:     st_nxt = BIL_ST_RST;
    endcase
  end

  // command bits go out on line 0, msb first, changed while the clock is low
  assign sh_nxt = (st_nxt == BIL_ST_SEL) ? {`BIL_READ_CMD, `BIL_FLASH_ADDR} :
                  (per_end && (st_r == BIL_ST_CMD)) ? {sh_r[30:0], 1'b0} : sh_r;

  always_comb begin
    qo_nxt.ss_n = !in_flash;
    qo_nxt.sclk = sclk_hi;
    qo_nxt.d_o  = {3'h0, sh_nxt[31]};
    qo_nxt.d_oe = drive_cmd ? 4'h1 : 4'h0;
  end

  // straps and data lines are pins: three stages, accepted when 2 and 3 agree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_s3_r <= 3'h0;
      strap_f_r  <= 3'h0;
      dq_s1_r    <= 4'h0;
      dq_s2_r    <= 4'h0;
      dq_s3_r    <= 4'h0;
      dq_f_r     <= 4'h0;
    end else begin
      strap_s1_r <= boot_strap_i;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      strap_f_r  <= (strap_s2_r == strap_s3_r) ? strap_s3_r : strap_f_r;
      dq_s1_r    <= quad_data_lines_i;
      dq_s2_r    <= dq_s1_r;
      dq_s3_r    <= dq_s2_r;
      dq_f_r     <= (dq_s2_r == dq_s3_r) ? dq_s3_r : dq_f_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= BIL_ST_RST;
      rst_cnt_r  <= 11'h000;
      cfg_r      <= '{tile0: BIL_MODE_NONE, tile1: BIL_MODE_NONE, link0_en: 1'b0, link0_2w: 1'b0};
      pin_en_r   <= 1'b0;
      pulldown_r <= 1'b1;
      run_r      <= 1'b0;
      err_r      <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      rst_cnt_r <= (st_r == BIL_ST_RST && !rst_done) ? rst_cnt_r + 11'h001 : rst_cnt_r;
      run_r     <= (st_nxt == BIL_ST_RUN);
      err_r     <= (st_nxt == BIL_ST_ERR);
      if (rst_done) begin
        cfg_r      <= secure ? bil_boot_cfg_t'{tile0: BIL_MODE_OTP, tile1: cfg_dec.tile1,
                                               link0_en: cfg_dec.link0_en,
                                               link0_2w: cfg_dec.link0_2w} : cfg_dec;
        // fixed pad set, no pin selection exists in this logic
        pin_en_r   <= !secure && (cfg_dec.tile0 == BIL_MODE_QSPI_M);
        pulldown_r <= secure || (cfg_dec.tile0 != BIL_MODE_QSPI_M);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qo_r      <= '{ss_n: 1'b1, sclk: 1'b0, d_o: 4'h0, d_oe: 4'h0};
      div_r     <= 3'h0;
      bit_cnt_r <= 6'h00;
      sh_r      <= 32'h0000_0000;
      nib_lo_r  <= 4'h0;
      nib_hi_r  <= 1'b0;
    end else begin
      qo_r      <= qo_nxt;
      sh_r      <= sh_nxt;
      div_r     <= clk_run ? div_r + 3'h1 : 3'h0;
      bit_cnt_r <= (per_end && st_r == BIL_ST_CMD) ? bit_cnt_r + 6'h01 : bit_cnt_r;
      if (nib_take) begin
        nib_lo_r <= dq_f_r;
        nib_hi_r <= !nib_hi_r;
      end
    end
  end

  // image parser shared by flash and OTP sources
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r       <= BIL_PH_SIZE;
      pos_r      <= 2'h0;
      word_sh_r  <= 32'h0000_0000;
      size_r     <= 32'h0000_0000;
      wr_cnt_r   <= 32'h0000_0000;
      wr_addr_r  <= `BIL_RAM_START;
      chk_r      <= 32'h0000_0000;
      size_bad_r <= 1'b0;
    end else if (byte_vld) begin
      pos_r     <= pos_r + 2'h1;
      word_sh_r <= word_val;
      if (word_done) begin
        case (ph_r)
          BIL_PH_SIZE: begin
            size_r     <= word_val;
            size_bad_r <= (word_val > RAM_WORDS);
            ph_r       <= (word_val == 32'h0) ? BIL_PH_CRC : BIL_PH_PROG;
          end
          BIL_PH_PROG: begin
            wr_cnt_r  <= wr_cnt_r + 32'h1;
            wr_addr_r <= wr_addr_r + `BIL_RAM_AW'(1);
            ph_r      <= prog_last ? BIL_PH_CRC : BIL_PH_PROG;
          end
          default: begin
            chk_r <= word_val;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_rd_r   <= 1'b0;
      otp_pend_r <= 1'b0;
      otp_addr_r <= `BIL_OTP_START;
    end else begin
      otp_rd_r <= (st_nxt == BIL_ST_OTP) && !otp_pend_r && !otp_rd_r && !img_done;
      if (otp_rd_r) begin
        otp_pend_r <= 1'b1;
      end else if (otp_take) begin
        otp_pend_r <= 1'b0;
        otp_addr_r <= otp_addr_r + `BIL_OTP_AW'(1);
      end
    end
  end

  bil_crc32 u_crc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .init_i  (rst_done),
    .en_i    (crc_en),
    .byte_i  (byte_val),
    .crc_o   (crc)
  );

  bil_ram u_ram (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .we_i    (ram_we && !size_bad_r),
    .waddr_i (wr_addr_r),
    .wdata_i (word_val),
    .raddr_i (ram_raddr_i),
    .rdata_o (ram_rdata_o)
  );

  assign qspi_o          = qo_r;
  assign qspi_pin_en_o   = pin_en_r;
  assign gpio_pulldown_o = pulldown_r;
  assign otp_rd_o        = otp_rd_r;
  assign otp_addr_o      = otp_addr_r;
  assign boot_cfg_o      = cfg_r;
  assign exec_start_o    = run_r;
  assign exec_addr_o     = `BIL_RAM_START;
  assign boot_error_o    = err_r;

  property p_rst_quiet;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_RST) |-> (gpio_pulldown_o && qspi_o.ss_n && !otp_rd_o);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("boot activity during reset phase");

  property p_rst_phase;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_RST && rst_cnt_r != RST_LAST) |=> (st_r == BIL_ST_RST);
  endproperty
  a_rst_phase: assert property (p_rst_phase) else $error("boot started before reset phase ended");

  property p_secure;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rst_done && secure) |=> (st_r == BIL_ST_OTP && qspi_o.ss_n && otp_addr_o == `BIL_OTP_START);
  endproperty
  a_secure: assert property (p_secure) else $error("secure bit did not select otp at zero");

  property p_sclk_div;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(qspi_o.sclk) |-> qspi_o.sclk [*4] ##1 !qspi_o.sclk [*4];
  endproperty
  a_sclk_div: assert property (p_sclk_div) else $error("serial clock not core clock over eight");

  property p_sclk_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    qspi_o.ss_n |-> !qspi_o.sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock active without select");

  property p_cmd_first;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_SEL) |-> (qspi_o.d_oe == 4'h1 && !qspi_o.ss_n && qspi_o.d_o[0] == sh_r[31]
                              && sh_r == {`BIL_READ_CMD, `BIL_FLASH_ADDR});
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("command start bit wrong");

  property p_bypass;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_CHK && bypass && !size_bad_r) |=> (st_r == BIL_ST_RUN) ##1 exec_start_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass word did not start execution");

  property p_crc_fail;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_CHK && !bypass && (~crc) != chk_r) |=> ##1 (boot_error_o && !exec_start_o);
  endproperty
  a_crc_fail: assert property (p_crc_fail) else $error("crc mismatch not flagged");

  property p_first_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ram_we |-> (wr_addr_r == `BIL_RAM_START + wr_cnt_r[`BIL_RAM_AW-1:0]);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("program not loaded from ram base");

  property p_select_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == BIL_ST_DATA && !img_done) |=> !qspi_o.ss_n;
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("select dropped before check word");

endmodule

// *** rtl/bil_ram.sv ***
/*
  Program RAM of the tile: one write port for the loader, one read port
  whose data come out of a register.
  Assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`include "bil_consts.svh"

module bil_ram (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   we_i,
  input  wire logic [`BIL_RAM_AW-1:0] waddr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic [`BIL_RAM_AW-1:0] raddr_i,
  output logic      [31:0]            rdata_o
);

  logic [31:0] mem [0:(1<<`BIL_RAM_AW)-1];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule
